// ==== common/pfc_trim_cfg.svh ====
`ifndef PFC_TRIM_CFG_SVH
`define PFC_TRIM_CFG_SVH

// Register addresses on the internal command port
`define ADDR_METER_GAIN_TRIM_HIGH_LINE 16'hfe8f
`define ADDR_ILOOP_GAIN_LOW_LINE_LIGHT 16'hfe90
`define ADDR_ILOOP_ZERO_LOW_LINE_LIGHT 16'hfe91
`define ADDR_ILOOP_GAIN_HIGH_LINE_LIGHT 16'hfe92
`define ADDR_ILOOP_ZERO_HIGH_LINE_LIGHT 16'hfe93
`define ADDR_SMART_OUTPUT_VOLTAGE_POWER_AVERAGE 16'hfe94
`define ADDR_CURRENT_BALANCE_CONFIG 16'hfe95

// Field positions
`define TRIM_SIGN_BIT 7
`define TRIM_MAG_MSB 6
`define CBAL_DISCONNECT_BIT 7
`define CBAL_FAST_LOOP_BIT 6
`define CBAL_LOW_POWER_BIT 3
`define CBAL_WRITABLE_MASK 8'hc8

// Reset values
`define RST_METER_GAIN_TRIM 8'h00
`define RST_ILOOP_COEF 8'h00
`define RST_CURRENT_BALANCE_CONFIG 8'h00

// One trim step is 0.0625/128 = 1/2048 of the reading
`define TRIM_STEP_SHIFT 11
// Averaging window in whole line cycles, and its log2
`define AVG_LINE_CYCLES 16
`define AVG_SHIFT 4

`endif

// ==== common/pfc_trim_pkg.sv ====
package pfc_trim_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
endpackage : pfc_trim_pkg

// ==== common/pwr_avg_if.sv ====
`timescale 1ns/10ps
interface pwr_avg_if;
  logic [15:0] sample;
  logic        cycle_end;
  logic [15:0] average;
  modport avg (input sample, input cycle_end, output average);
  modport host (output sample, output cycle_end, input average);
endinterface : pwr_avg_if

// ==== rtl/smart_output_voltage_power_avg.sv ====
`timescale 1ns/10ps
`include "pfc_trim_cfg.svh"
module smart_output_voltage_power_avg #(
  parameter int CYCLES = `AVG_LINE_CYCLES,
  parameter int SHIFT  = `AVG_SHIFT
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Power samples in, average out
  pwr_avg_if.avg    pa
);
  import pfc_trim_pkg::*;

  logic [SHIFT-1:0]    count;
  logic [SHIFT-1:0]    next_count;
  logic [16+SHIFT-1:0] sum;
  logic [16+SHIFT-1:0] next_sum;
  word_t               average;
  word_t               next_average;
  logic [16+SHIFT-1:0] total;

  // One sample per full line cycle; average lands after the last one
  always_comb begin
    next_count   = count;
    next_sum     = sum;
    next_average = average;
    total        = sum + {{SHIFT{1'b0}}, pa.sample};
    if (pa.cycle_end) begin
      if (count == SHIFT'(CYCLES - 1)) begin
        next_average = word_t'(total >> SHIFT); // see R05
        next_sum     = '0;
        next_count   = '0;
      end else begin
        next_sum   = total;
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count   <= '0;
      sum     <= '0;
      average <= 16'h0000;
    end else begin
      count   <= next_count;
      sum     <= next_sum;
      average <= next_average;
    end
  end

  assign pa.average = average;
endmodule : smart_output_voltage_power_avg

// ==== rtl/pfc_trim_filter_balance_regs.sv ====
// Overview of operation
// R01: Trim bit 7 set means negative gain.
// R02: Scale high-line reading by magnitude/2048 steps.
// R03: Low-line light-load coefficients used when selected.
// R04: High-line light-load coefficients used when selected.
// R05: Read-only power averaged over sixteen line cycles.
// R06: Config bit 7 disconnects balance from PWM.
// R07: Config bit 6 allows balancing during fast loop.
// R08: Config bit 3 stops low-power balancing at limit.
// R09: Select clear keeps normal loop coefficients.
`timescale 1ns/10ps
`include "pfc_trim_cfg.svh"
module pfc_trim_filter_balance_regs #(
  parameter int BAL_W = 10
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Register command port from the PMBus slave
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [15:0]          cmd_addr,
  input  wire pfc_trim_pkg::word_t  cmd_wdata,
  output logic                      rsp_valid,
  output pfc_trim_pkg::word_t       rsp_rdata,
  output logic                      rsp_err,
  // Power meter path
  input  wire logic                 meter_valid,
  input  wire pfc_trim_pkg::word_t  meter_raw,
  input  wire logic                 line_cycle_end,
  output pfc_trim_pkg::word_t       meter_trimmed,
  // Current loop coefficient selection
  input  wire logic                 high_line,
  input  wire logic                 light_load,
  input  wire logic                 light_coef_select,
  input  wire pfc_trim_pkg::byte_t  normal_iloop_gain,
  input  wire pfc_trim_pkg::byte_t  normal_iloop_zero,
  output pfc_trim_pkg::byte_t       iloop_gain,
  output pfc_trim_pkg::byte_t       iloop_zero,
  // Current balance path
  input  wire logic [BAL_W-1:0]     current_balance_in,
  input  wire logic                 current_balance_at_limit,
  input  wire logic                 fast_loop_active,
  input  wire logic                 low_power_mode,
  output logic [BAL_W-1:0]          current_balance_to_pwm,
  output logic                      current_balance_active
);
  import pfc_trim_pkg::*;

  // Register bank, cleared by reset
  byte_t meter_gain_trim_high_line;
  byte_t iloop_gain_low_line_light;
  byte_t iloop_zero_low_line_light;
  byte_t iloop_gain_high_line_light;
  byte_t iloop_zero_high_line_light;
  byte_t current_balance_config;

  // Next values for the bank and the outputs
  byte_t next_meter_gain_trim_high_line;
  byte_t next_iloop_gain_low_line_light;
  byte_t next_iloop_zero_low_line_light;
  byte_t next_iloop_gain_high_line_light;
  byte_t next_iloop_zero_high_line_light;
  byte_t next_current_balance_config;
  logic  next_rsp_valid;
  word_t next_rsp_rdata;
  logic  next_rsp_err;
  word_t next_meter_trimmed;
  byte_t next_iloop_gain;
  byte_t next_iloop_zero;
  logic [BAL_W-1:0] next_current_balance_to_pwm;
  logic  next_current_balance_active;
  word_t power_average;
  logic  pause_fast_loop;
  logic  pause_at_limit;

  pwr_avg_if pa ();

  // Averaging takes the trimmed reading once per line cycle
  assign pa.sample    = meter_trimmed;
  assign pa.cycle_end = line_cycle_end;
  assign power_average = pa.average;

  // Same clock as the bank, so nothing crosses on the interface
  smart_output_voltage_power_avg #(
    .CYCLES (`AVG_LINE_CYCLES),
    .SHIFT  (`AVG_SHIFT)
  ) u_avg (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pa       (pa)
  );

  // Signed-magnitude trim; correction is under 1/16 so no underflow
  // Truncating the correction biases it slightly toward zero
  function automatic word_t apply_trim(input word_t raw, input byte_t trim);
    logic [22:0] prod;
    logic [16:0] sum;
    word_t       corr;
    prod = raw * trim[`TRIM_MAG_MSB:0];             // see R02
    corr = word_t'(prod >> `TRIM_STEP_SHIFT);       // see R02
    sum  = {1'b0, raw} + {1'b0, corr};
    if (trim[`TRIM_SIGN_BIT]) begin
      apply_trim = raw - corr;                       // see R01
    end else if (sum[16]) begin
      apply_trim = 16'hffff;                         // Saturate, never wrap
    end else begin
      apply_trim = sum[15:0];                        // see R01
    end
  endfunction : apply_trim

  // Register writes and read answers, one cycle after the command
  // A read in the cycle of a write still returns the old value
  always_comb begin
    next_meter_gain_trim_high_line  = meter_gain_trim_high_line;
    next_iloop_gain_low_line_light  = iloop_gain_low_line_light;
    next_iloop_zero_low_line_light  = iloop_zero_low_line_light;
    next_iloop_gain_high_line_light = iloop_gain_high_line_light;
    next_iloop_zero_high_line_light = iloop_zero_high_line_light;
    next_current_balance_config     = current_balance_config;
    next_rsp_valid = cmd_valid;
    next_rsp_rdata = 16'h0000;
    next_rsp_err   = 1'b0;
    if (cmd_valid) begin
      if (cmd_addr == `ADDR_METER_GAIN_TRIM_HIGH_LINE) begin
        next_rsp_rdata = {8'h00, meter_gain_trim_high_line};
        if (cmd_write) next_meter_gain_trim_high_line = cmd_wdata[7:0];
      end else if (cmd_addr == `ADDR_ILOOP_GAIN_LOW_LINE_LIGHT) begin
        next_rsp_rdata = {8'h00, iloop_gain_low_line_light};
        if (cmd_write) next_iloop_gain_low_line_light = cmd_wdata[7:0];
      end else if (cmd_addr == `ADDR_ILOOP_ZERO_LOW_LINE_LIGHT) begin
        next_rsp_rdata = {8'h00, iloop_zero_low_line_light};
        if (cmd_write) next_iloop_zero_low_line_light = cmd_wdata[7:0];
      end else if (cmd_addr == `ADDR_ILOOP_GAIN_HIGH_LINE_LIGHT) begin
        next_rsp_rdata = {8'h00, iloop_gain_high_line_light};
        if (cmd_write) next_iloop_gain_high_line_light = cmd_wdata[7:0];
      end else if (cmd_addr == `ADDR_ILOOP_ZERO_HIGH_LINE_LIGHT) begin
        next_rsp_rdata = {8'h00, iloop_zero_high_line_light};
        if (cmd_write) next_iloop_zero_high_line_light = cmd_wdata[7:0];
      end else if (cmd_addr == `ADDR_SMART_OUTPUT_VOLTAGE_POWER_AVERAGE) begin
        next_rsp_rdata = power_average;                // see R05
        next_rsp_err   = cmd_write;                    // Read-only
      end else if (cmd_addr == `ADDR_CURRENT_BALANCE_CONFIG) begin
        next_rsp_rdata = {8'h00, current_balance_config};
        if (cmd_write) begin
          // Reserved bits stay zero
          next_current_balance_config = cmd_wdata[7:0] & `CBAL_WRITABLE_MASK;
        end
      end else begin
        // Unmapped address: error answer with zero data
        next_rsp_err = 1'b1;
      end
    end
  end

  // Datapath: trimmed meter, chosen coefficients, balance gating
  always_comb begin
    next_meter_trimmed = meter_trimmed;
    if (meter_valid) begin
      // Trim only acts at high line
      next_meter_trimmed = high_line ? apply_trim(meter_raw, meter_gain_trim_high_line) : meter_raw;
    end
    next_iloop_gain = normal_iloop_gain;               // see R09
    next_iloop_zero = normal_iloop_zero;               // see R09
    // Light-load set only while the select bit is set
    if (light_coef_select && light_load) begin
      if (high_line) begin
        next_iloop_gain = iloop_gain_high_line_light;  // see R04
        next_iloop_zero = iloop_zero_high_line_light;  // see R04
      end else begin
        next_iloop_gain = iloop_gain_low_line_light;   // see R03
        next_iloop_zero = iloop_zero_low_line_light;   // see R03
      end
    end
    // Fast loop pauses balancing unless the config lets it ride through
    pause_fast_loop = fast_loop_active && !current_balance_config[`CBAL_FAST_LOOP_BIT];   // see R07
    // Low power pauses it only once the balance output sits at its limit
    pause_at_limit  = low_power_mode && current_balance_at_limit &&
                      current_balance_config[`CBAL_LOW_POWER_BIT];                       // see R08
    next_current_balance_active = !pause_fast_loop && !pause_at_limit;
    // Disconnected or paused balance contributes nothing to the PWM
    if (current_balance_config[`CBAL_DISCONNECT_BIT] || !next_current_balance_active) begin
      next_current_balance_to_pwm = '0;                // see R06
    end else begin
      next_current_balance_to_pwm = current_balance_in; // see R06
    end
  end

  // Only registering here; all decisions are in the comb blocks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Bank to its reset values
      meter_gain_trim_high_line  <= `RST_METER_GAIN_TRIM;
      iloop_gain_low_line_light  <= `RST_ILOOP_COEF;
      iloop_zero_low_line_light  <= `RST_ILOOP_COEF;
      iloop_gain_high_line_light <= `RST_ILOOP_COEF;
      iloop_zero_high_line_light <= `RST_ILOOP_COEF;
      current_balance_config     <= `RST_CURRENT_BALANCE_CONFIG;
      // Outputs idle through reset
      rsp_valid              <= 1'b0;
      rsp_rdata              <= 16'h0000;
      rsp_err                <= 1'b0;
      meter_trimmed          <= 16'h0000;
      iloop_gain             <= 8'h00;
      iloop_zero             <= 8'h00;
      current_balance_to_pwm <= '0;
      current_balance_active <= 1'b0;
    end else begin
      meter_gain_trim_high_line  <= next_meter_gain_trim_high_line;
      iloop_gain_low_line_light  <= next_iloop_gain_low_line_light;
      iloop_zero_low_line_light  <= next_iloop_zero_low_line_light;
      iloop_gain_high_line_light <= next_iloop_gain_high_line_light;
      iloop_zero_high_line_light <= next_iloop_zero_high_line_light;
      current_balance_config     <= next_current_balance_config;
      // Outputs straight from flops
      rsp_valid              <= next_rsp_valid;
      rsp_rdata              <= next_rsp_rdata;
      rsp_err                <= next_rsp_err;
      meter_trimmed          <= next_meter_trimmed;
      iloop_gain             <= next_iloop_gain;
      iloop_zero             <= next_iloop_zero;
      current_balance_to_pwm <= next_current_balance_to_pwm;
      current_balance_active <= next_current_balance_active;
    end
  end
endmodule : pfc_trim_filter_balance_regs

// ==== tb/pfc_regs_checker_properties.sv ====
`timescale 1ns/10ps
module pfc_regs_checker #(parameter int BAL_W = 10) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             reset_n,
  // Command port
  input wire logic             cmd_valid,
  input wire logic             cmd_write,
  input wire logic [15:0]      cmd_addr,
  input wire logic [15:0]      cmd_wdata,
  input wire logic             rsp_valid,
  input wire logic [15:0]      rsp_rdata,
  input wire logic             rsp_err,
  // Coefficients and balance
  input wire logic             light_load,
  input wire logic             light_coef_select,
  input wire logic [7:0]       normal_iloop_gain,
  input wire logic [7:0]       iloop_gain,
  input wire logic [BAL_W-1:0] current_balance_in,
  input wire logic             current_balance_at_limit,
  input wire logic             fast_loop_active,
  input wire logic             low_power_mode,
  input wire logic [BAL_W-1:0] current_balance_to_pwm,
  input wire logic             current_balance_active
);
  import pfc_trim_pkg::*;
  byte_t            cfg, next_cfg;
  logic             unmapped, want_active;
  logic [BAL_W-1:0] want_pwm;
  // Config shadow, so pause and cut-off can be predicted
  always_comb begin
    next_cfg = (cmd_valid && cmd_write && cmd_addr == 16'hfe95) ? (cmd_wdata[7:0] & 8'hc8) : cfg;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cfg <= 8'h00;
    else cfg <= next_cfg;
  end
  // Refused addresses and predicted balance outputs
  assign unmapped = cmd_addr < 16'hfe8f || cmd_addr > 16'hfe95;
  assign want_active = !(fast_loop_active && !cfg[6]) && !(low_power_mode && current_balance_at_limit && cfg[3]);
  assign want_pwm = cfg[7] ? '0 : current_balance_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_rsp_pulse: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer");
  a_rsp_quiet: assert property (!cmd_valid |=> !rsp_valid)
    else $error("stray answer");
  a_unmapped_err: assert property (cmd_valid && unmapped |=> rsp_err && rsp_rdata == 16'h0000)
    else $error("unmapped not refused");
  a_ro_refused: assert property (cmd_valid && cmd_write && cmd_addr == 16'hfe94 |=> rsp_err)
    else $error("reading write not refused");
  a_cfg_readback: assert property (
    cmd_valid && !cmd_write && cmd_addr == 16'hfe95 |=> rsp_rdata == {8'h00, $past(cfg)})
    else $error("config readback wrong");
  a_coef_normal: assert property (
    !(light_coef_select && light_load) |=> iloop_gain == $past(normal_iloop_gain))
    else $error("normal gain not used");
  a_bal_pause: assert property (
    1'b1 |=> current_balance_active == $past(want_active))
    else $error("balance pause wrong");
  a_bal_pwm: assert property (
    1'b1 |=> current_balance_to_pwm == ($past(want_active) ? $past(want_pwm) : '0))
    else $error("balance output wrong");
  c_unmapped: cover property (cmd_valid && unmapped);
  c_paused: cover property (!current_balance_active);
  c_light: cover property (light_coef_select && light_load);
endmodule : pfc_regs_checker
bind pfc_trim_filter_balance_regs pfc_regs_checker #(.BAL_W(BAL_W)) pfc_regs_checker_inst (
  .core_clk, .reset_n, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_err,
  .light_load, .light_coef_select, .normal_iloop_gain, .iloop_gain, .current_balance_in,
  .current_balance_at_limit, .fast_loop_active, .low_power_mode, .current_balance_to_pwm, .current_balance_active);

// ==== tb/pmb_host.sv ====
`timescale 1ns/10ps
module pmb_host (
  // Clock
  input wire logic            core_clk,
  // Command port
  output logic                cmd_valid,
  output logic                cmd_write,
  output logic [15:0]         cmd_addr,
  output pfc_trim_pkg::word_t cmd_wdata
);
  import pfc_trim_pkg::*;
  // Idle port at time zero
  initial begin
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
  end
  // One command a cycle; caller sits just after an edge
  task automatic xfer(input logic w, input logic [15:0] a, input word_t d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge core_clk);
    #1;
  endtask : xfer
  // Release; stale address and data scrambled so nothing relies on them
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_addr = ~cmd_addr;
    cmd_wdata = ~cmd_wdata;
    @(posedge core_clk);
    #1;
  endtask : idle
endmodule : pmb_host

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import pfc_trim_pkg::*;
  localparam int BAL_W = 10;
  logic             core_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             cmd_valid, cmd_write, rsp_valid, rsp_err, meter_valid, line_cycle_end, high_line, light_load;
  logic             light_coef_select, current_balance_at_limit, fast_loop_active, low_power_mode;
  logic             current_balance_active, act;
  logic [15:0]      cmd_addr;
  word_t            cmd_wdata, rsp_rdata, meter_raw, meter_trimmed, raw;
  byte_t            normal_iloop_gain, normal_iloop_zero, iloop_gain, iloop_zero, t, coef[4];
  logic [BAL_W-1:0] current_balance_in, current_balance_to_pwm;
  logic [17:0]      notes[$], note;
  logic [31:0]      sum;
  int               errors = 0, checks = 0, seed = 32'h1d539b6d;
  word_t            cfgs[5] = '{16'h00ff, 16'h0008, 16'h0040, 16'h0080, 16'h0000};
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  pfc_trim_filter_balance_regs #(.BAL_W(BAL_W)) pfc_trim_filter_balance_regs_inst (
    .core_clk (core_clk), .reset_n (reset_n),
    .cmd_valid (cmd_valid), .cmd_write (cmd_write), .cmd_addr (cmd_addr), .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid), .rsp_rdata (rsp_rdata), .rsp_err (rsp_err),
    .meter_valid (meter_valid), .meter_raw (meter_raw), .line_cycle_end (line_cycle_end),
    .meter_trimmed (meter_trimmed), .high_line (high_line), .light_load (light_load),
    .light_coef_select (light_coef_select), .normal_iloop_gain (normal_iloop_gain),
    .normal_iloop_zero (normal_iloop_zero), .iloop_gain (iloop_gain), .iloop_zero (iloop_zero),
    .current_balance_in (current_balance_in), .current_balance_at_limit (current_balance_at_limit),
    .fast_loop_active (fast_loop_active), .low_power_mode (low_power_mode),
    .current_balance_to_pwm (current_balance_to_pwm), .current_balance_active (current_balance_active));
  pmb_host pmb_host_inst (
    .core_clk (core_clk), .cmd_valid (cmd_valid), .cmd_write (cmd_write),
    .cmd_addr (cmd_addr), .cmd_wdata (cmd_wdata));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Note the answer first; the monitor may see it one edge later
  task automatic cmd(input logic w, input int a, input word_t d, input logic rd, input word_t exp, input logic err);
    notes.push_back({rd, err, exp});
    pmb_host_inst.xfer(w, 16'(a), d);
  endtask : cmd
  // Floor of the step correction, add side clipped at full scale
  function automatic word_t trim(input word_t r, input byte_t g, input logic hl);
    logic [31:0] c;
    c = ({16'h0000, r} * g[6:0]) >> 11;
    if (!hl) return r;
    if (g[7]) return r - c[15:0];
    c = c + r;
    return (c > 32'hffff) ? 16'hffff : c[15:0];
  endfunction : trim
  // Answers paired with the oldest note
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      note = notes.pop_front();
      chk("rsp_err", rsp_err, note[16]);
      if (note[17]) chk("rsp_rdata", rsp_rdata, note[15:0]);
    end
  end
  initial begin
    {meter_valid, line_cycle_end, high_line, light_load, light_coef_select} = '0;
    {current_balance_at_limit, fast_loop_active, low_power_mode} = '0;
    {meter_raw, normal_iloop_gain, normal_iloop_zero, current_balance_in} = '0;
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    // Reset values, then back-to-back write and read of the five trim and coefficient registers
    for (int a = 0; a < 7; a++) cmd(0, 16'hfe8f + a, 0, 1, 0, 0);
    for (int a = 0; a < 5; a++) begin
      t = 8'($random(seed));
      if (a > 0) coef[a-1] = t;
      cmd(1, 16'hfe8f + a, {8'hff, t}, 0, 0, 0);
      cmd(0, 16'hfe8f + a, 0, 1, {8'h00, t}, 0);
    end
    // Reserved bits, read-only write, both neighbours of the bank
    cmd(1, 16'hfe95, 16'hffff, 0, 0, 0);
    cmd(0, 16'hfe95, 0, 1, 16'h00c8, 0);
    cmd(1, 16'hfe94, 16'h1234, 0, 0, 1);
    cmd(0, 16'hfe8e, 0, 1, 0, 1);
    cmd(1, 16'hfe96, 16'h00ff, 1, 0, 1);
    // Both signs at both line levels; i of 1 saturates
    for (int i = 0; i < 8; i++) begin
      t = (i == 1) ? 8'h7f : {i[1], 7'($random(seed))};
      raw = (i == 1) ? 16'hffff : 16'($random(seed));
      cmd(1, 16'hfe8f, {8'h00, t}, 0, 0, 0);
      pmb_host_inst.idle();
      {high_line, meter_raw, meter_valid} = {i[0], raw, 1'b1};
      @(posedge core_clk);
      #1;
      meter_valid = 1'b0;
      chk("meter_trimmed", meter_trimmed, trim(raw, t, high_line));
    end
    // One full window at low line; halfway the reading still shows zero
    {high_line, sum} = '0;
    for (int k = 0; k < 16; k++) begin
      if (k == 8) cmd(0, 16'hfe94, 0, 1, 0, 0);
      pmb_host_inst.idle();
      meter_raw = 16'($random(seed));
      sum += meter_raw;
      meter_valid = 1'b1;
      @(posedge core_clk);
      #1;
      {meter_valid, line_cycle_end} = 2'b01;
      @(posedge core_clk);
      #1;
      line_cycle_end = 1'b0;
    end
    pmb_host_inst.idle();
    cmd(0, 16'hfe94, 0, 1, 16'(sum >> 4), 0);
    pmb_host_inst.idle();
    // Every select, load and line combination
    for (int c = 0; c < 8; c++) begin
      {light_coef_select, light_load, high_line} = 3'(c);
      {normal_iloop_gain, normal_iloop_zero} = 16'($random(seed));
      @(posedge core_clk);
      #1;
      chk("iloop_gain", iloop_gain, (c > 5) ? coef[{c[0], 1'b0}] : normal_iloop_gain);
      chk("iloop_zero", iloop_zero, (c > 5) ? coef[{c[0], 1'b1}] : normal_iloop_zero);
    end
    // Each config, then random balance traffic judged by the checker
    foreach (cfgs[j]) begin
      cmd(1, 16'hfe95, cfgs[j], 0, 0, 0);
      cmd(0, 16'hfe95, 0, 1, cfgs[j] & 16'h00c8, 0);
      pmb_host_inst.idle();
      repeat (24) begin
        current_balance_in = BAL_W'($random(seed));
        {current_balance_at_limit, fast_loop_active, low_power_mode} = 3'($random(seed));
        @(posedge core_clk);
        #1;
        act = !(fast_loop_active && !cfgs[j][6]) && !(low_power_mode && current_balance_at_limit && cfgs[j][3]);
        chk("current_balance_active", current_balance_active, act);
        chk("current_balance_to_pwm", current_balance_to_pwm, (act && !cfgs[j][7]) ? current_balance_in : 0);
      end
    end
    chk("pending answers", notes.size(), 0);
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule : testbench
